// >>> shared/occs_map.vh
`ifndef OCCS_MAP_VH
`define OCCS_MAP_VH

// Register indices; byte address is the index times four
`define OCCS_CTL_IDX        12'hF86
`define OCCS_STAT_IDX       12'hF87
`define OCCS_TRIM_IDX       12'hF88
`define OCCS_CTL_ADDR       {`OCCS_CTL_IDX, 2'b00}
`define OCCS_STAT_ADDR      {`OCCS_STAT_IDX, 2'b00}
`define OCCS_TRIM_ADDR      {`OCCS_TRIM_IDX, 2'b00}

// Control register fields and reset value
`define OCCS_CTL_RESET      8'hA0
`define OCCS_BIT_PREC_EN    7
`define OCCS_BIT_XTAL_EN    6
`define OCCS_BIT_WDOSC_EN   5
`define OCCS_BIT_PFAIL_EN   4
`define OCCS_BIT_WFAIL_EN   3
`define OCCS_SEL_HI         2
`define OCCS_SEL_LO         0

// Status register fields
`define OCCS_ST_PFAIL       0
`define OCCS_ST_WFAIL       1
`define OCCS_ST_PREC_RDY    2
`define OCCS_ST_UNLOCKED    3
`define OCCS_ST_SEL_LO      4
`define OCCS_ST_SEL_HI      6

// Unlock keys
`define OCCS_KEY_FIRST      8'hE7
`define OCCS_KEY_SECOND     8'h18

// Clock source select codes
`define OCCS_SRC_PREC_FAST  3'h0
`define OCCS_SRC_PREC_SLOW  3'h1
`define OCCS_SRC_XTAL       3'h2
`define OCCS_SRC_WDOSC      3'h3
`define OCCS_SRC_EXTPIN     3'h4

// Timing
`define OCCS_REF_PERIOD_PS  5000
`define OCCS_PREC_START_NS  25000
`define OCCS_PREC_START_CYC ((`OCCS_PREC_START_NS * 1000) / `OCCS_REF_PERIOD_PS)
`define OCCS_WDOSC_FAIL_CYC 14'h1F44

`endif

// >>> hw/occs_wdosc_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "occs_map.vh"

module occs_wdosc_monitor
(
   input  wire       ref_clk,    // System clock
   input  wire       sys_rst,    // Async reset, high
   input  wire       enable,     // Watch for watchdog oscillator edges
   input  wire       wd_edge,    // One cycle per watchdog oscillator edge
   output reg        fail_pulse  // One cycle on detected failure
);

   reg [13:0] count_reg;

   // Count system clocks between watchdog edges; a slow system clock means slow detection
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         count_reg  <= 14'h0000;
         fail_pulse <= 1'b0;
      end
      else
      begin
         fail_pulse <= 1'b0;
         if (!enable || wd_edge)
            count_reg <= 14'h0000;
         else if (count_reg == `OCCS_WDOSC_FAIL_CYC - 14'h0001)
         begin
            count_reg  <= 14'h0000;
            fail_pulse <= 1'b1;
         end
         else
            count_reg <= count_reg + 14'h0001;
      end
   end

endmodule
`default_nettype wire

// >>> hw/occs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "occs_map.vh"

module occs_top
#(
   parameter PREC_START_CYC = `OCCS_PREC_START_CYC        // Precision oscillator settle count
)
(
   input  wire        ref_clk,                 // System clock, 200 MHz
   input  wire        sys_rst,                 // Async reset, high
   input  wire [13:0] avs_address,             // Byte address
   input  wire        avs_read,                // Read request
   input  wire        avs_write,               // Write request
   input  wire [31:0] avs_writedata,           // Write data
   input  wire [3:0]  avs_byteenable,          // Byte enables
   output reg  [31:0] avs_readdata,            // Read data
   output reg         avs_waitrequest,         // Stall
   input  wire        wd_osc_clk,              // Watchdog oscillator output, async
   input  wire        primary_osc_fail,        // Primary failure detector level, async
   input  wire        crystal_reset_disable_option, // Option: crystal off from reset release until software takes over
   input  wire [1:0]  crystal_mode_option,     // Option: crystal drive mode
   input  wire [7:0]  trim_option,             // Option: precision oscillator trim
   output reg         precision_rc_enable,     // Precision oscillator on
   output reg         precision_rc_fast,       // Precision oscillator fast mode
   output reg  [7:0]  precision_rc_trim,       // Trim to precision oscillator
   output reg         crystal_enable,          // Crystal oscillator on
   output reg         crystal_pin_override,    // Crystal pins taken from port logic
   output reg  [1:0]  crystal_mode,            // Crystal drive mode
   output reg         crystal_filter_enable,   // Crystal clock filter
   output reg         watchdog_osc_enable,     // Watchdog oscillator on
   output reg  [2:0]  sysclk_source_select,    // Effective clock mux select
   output reg         primary_fail_event,      // Pulse on primary failure
   output reg         wdosc_fail_event         // Pulse on watchdog oscillator failure
);

   localparam [1:0] LK_LOCKED = 2'h0;
   localparam [1:0] LK_FIRST  = 2'h1;
   localparam [1:0] LK_OPEN   = 2'h2;

   reg  [7:0]  ctl_reg;
   reg  [1:0]  lock_reg;
   reg  [7:0]  trim_reg;
   reg         trim_loaded_reg;
   reg         pfail_flag_reg;
   reg         wfail_flag_reg;
   reg         prec_ready_reg;
   reg  [12:0] prec_count_reg;
   reg         xtal_boot_reg;
   reg  [2:0]  sel_reg;
   reg  [2:0]  wd_sync_reg;
   reg  [1:0]  pf_sync_reg;
   reg         pf_prev_reg;
   reg  [7:0]  rd_next;
   reg         sel_ok;
   wire        bus_write;
   wire        wd_edge;
   wire        wfail_pulse;
   wire        pf_rise;
   wire        pf_detect;
   wire        lane0;
   wire [7:0]  wdata;
   wire [7:0]  stat_val;

   assign bus_write = avs_write && !avs_waitrequest;
   assign lane0     = avs_byteenable[0];
   assign wdata     = avs_writedata[7:0];
   assign wd_edge   = wd_sync_reg[1] ^ wd_sync_reg[2];
   assign pf_rise   = pf_sync_reg[1] && !pf_prev_reg;
   assign stat_val  = {1'b0, sel_reg, (lock_reg == LK_OPEN), prec_ready_reg, wfail_flag_reg, pfail_flag_reg};

   // Primary detection is lost after a watchdog failure and meaningless on the watchdog source
   assign pf_detect = ctl_reg[`OCCS_BIT_PFAIL_EN] && ctl_reg[`OCCS_BIT_WDOSC_EN] && !wfail_flag_reg
                      && (sel_reg != `OCCS_SRC_WDOSC);

   // Bus handshake: one wait cycle, then the access completes
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         avs_waitrequest <= 1'b1;
      else if ((avs_read || avs_write) && avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   // Read mux; unmapped addresses read zero
   always @*
   begin
      rd_next = 8'h00;
      case (avs_address)
         `OCCS_CTL_ADDR:  rd_next = ctl_reg;
         `OCCS_STAT_ADDR: rd_next = stat_val;
         `OCCS_TRIM_ADDR: rd_next = trim_reg;
         default:         rd_next = 8'h00;
      endcase
   end

   // Read data prepared during the wait cycle so it stands at the completing edge
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         avs_readdata <= 32'h00000000;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= {24'h000000, rd_next};
   end

   // Unlock sequencer; only control register writes move it
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         lock_reg <= LK_LOCKED;
      else if (bus_write && lane0 && avs_address == `OCCS_CTL_ADDR)
      begin
         case (lock_reg)
            LK_LOCKED: lock_reg <= (wdata == `OCCS_KEY_FIRST) ? LK_FIRST : LK_LOCKED;
            LK_FIRST:
            begin
               if (wdata == `OCCS_KEY_SECOND)
                  lock_reg <= LK_OPEN;
               else if (wdata == `OCCS_KEY_FIRST)
                  lock_reg <= LK_FIRST;
               else
                  lock_reg <= LK_LOCKED;
            end
            LK_OPEN:   lock_reg <= LK_LOCKED;
            default:   lock_reg <= LK_LOCKED;
         endcase
      end
   end

   // Control register; changes only on the write that follows a full unlock
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ctl_reg <= `OCCS_CTL_RESET;
      else if (bus_write && lane0 && avs_address == `OCCS_CTL_ADDR && lock_reg == LK_OPEN)
         ctl_reg <= wdata;
   end

   // Trim: option value caught after reset release, software may overwrite
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         trim_reg        <= 8'h00;
         trim_loaded_reg <= 1'b0;
      end
      else if (bus_write && lane0 && avs_address == `OCCS_TRIM_ADDR)
      begin
         trim_reg        <= wdata;
         trim_loaded_reg <= 1'b1;
      end
      else if (!trim_loaded_reg)
      begin
         trim_reg        <= trim_option;
         trim_loaded_reg <= 1'b1;
      end
   end

   // Synchronisers for the asynchronous oscillator and detector inputs
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wd_sync_reg <= 3'h0;
         pf_sync_reg <= 2'h0;
         pf_prev_reg <= 1'b0;
      end
      else
      begin
         wd_sync_reg <= {wd_sync_reg[1:0], wd_osc_clk};
         pf_sync_reg <= {pf_sync_reg[0], primary_osc_fail};
         pf_prev_reg <= pf_sync_reg[1];
      end
   end

   // Watchdog oscillator failure counter
   occs_wdosc_monitor u_wdmon
   (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .enable     (ctl_reg[`OCCS_BIT_WFAIL_EN] && ctl_reg[`OCCS_BIT_WDOSC_EN]),
      .wd_edge    (wd_edge),
      .fail_pulse (wfail_pulse)
   );

   // Sticky failure flags; a new event wins over a write-one clear
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pfail_flag_reg     <= 1'b0;
         wfail_flag_reg     <= 1'b0;
         primary_fail_event <= 1'b0;
         wdosc_fail_event   <= 1'b0;
      end
      else
      begin
         primary_fail_event <= pf_rise && pf_detect;
         wdosc_fail_event   <= wfail_pulse;
         if (pf_rise && pf_detect)
            pfail_flag_reg <= 1'b1;
         else if (bus_write && lane0 && avs_address == `OCCS_STAT_ADDR && wdata[`OCCS_ST_PFAIL])
            pfail_flag_reg <= 1'b0;
         if (wfail_pulse)
            wfail_flag_reg <= 1'b1;
         else if (bus_write && lane0 && avs_address == `OCCS_STAT_ADDR && wdata[`OCCS_ST_WFAIL])
            wfail_flag_reg <= 1'b0;
      end
   end

   // Precision oscillator start-up timer; restarts on every enable
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prec_count_reg <= 13'h0000;
         prec_ready_reg <= 1'b0;
      end
      else if (!ctl_reg[`OCCS_BIT_PREC_EN])
      begin
         prec_count_reg <= 13'h0000;
         prec_ready_reg <= 1'b0;
      end
      else if (!prec_ready_reg)
      begin
         if (prec_count_reg == PREC_START_CYC[12:0] - 13'h0001)
            prec_ready_reg <= 1'b1;
         else
            prec_count_reg <= prec_count_reg + 13'h0001;
      end
   end

   // Source readiness for the requested select; reserved codes never pass
   always @*
   begin
      sel_ok = 1'b0;
      case (ctl_reg[`OCCS_SEL_HI:`OCCS_SEL_LO])
         `OCCS_SRC_PREC_FAST: sel_ok = ctl_reg[`OCCS_BIT_PREC_EN] && prec_ready_reg;
         `OCCS_SRC_PREC_SLOW: sel_ok = ctl_reg[`OCCS_BIT_PREC_EN] && prec_ready_reg;
         `OCCS_SRC_XTAL:      sel_ok = crystal_enable;
         `OCCS_SRC_WDOSC:     sel_ok = ctl_reg[`OCCS_BIT_WDOSC_EN];
         `OCCS_SRC_EXTPIN:    sel_ok = 1'b1;
         default:             sel_ok = 1'b0;
      endcase
   end

   // Effective select: failover forces the watchdog source until software clears the primary failure flag
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         sel_reg <= `OCCS_SRC_PREC_FAST;
      else if (pf_rise && pf_detect)
         sel_reg <= `OCCS_SRC_WDOSC;
      else if (pfail_flag_reg && lock_reg != LK_LOCKED)
         sel_reg <= sel_reg;
      else if (sel_ok && lock_reg == LK_LOCKED && !pfail_flag_reg)
         sel_reg <= ctl_reg[`OCCS_SEL_HI:`OCCS_SEL_LO];
   end

   // Crystal: on from release unless the option disables it, until software takes over
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         xtal_boot_reg <= 1'b1;
      else if (bus_write && lane0 && avs_address == `OCCS_CTL_ADDR && lock_reg == LK_OPEN)
         xtal_boot_reg <= 1'b0;
   end

   // Registered oscillator controls
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         precision_rc_enable   <= 1'b1;
         precision_rc_fast     <= 1'b1;
         precision_rc_trim     <= 8'h00;
         crystal_enable        <= 1'b0;
         crystal_pin_override  <= 1'b0;
         crystal_mode          <= 2'h0;
         crystal_filter_enable <= 1'b0;
         watchdog_osc_enable   <= 1'b1;
         sysclk_source_select  <= `OCCS_SRC_PREC_FAST;
      end
      else
      begin
         precision_rc_enable   <= ctl_reg[`OCCS_BIT_PREC_EN];
         precision_rc_fast     <= (sel_reg != `OCCS_SRC_PREC_SLOW);
         precision_rc_trim     <= trim_reg;
         crystal_enable        <= ctl_reg[`OCCS_BIT_XTAL_EN]
                                  || (xtal_boot_reg && !crystal_reset_disable_option);
         crystal_pin_override  <= ctl_reg[`OCCS_BIT_XTAL_EN];
         crystal_mode          <= crystal_mode_option;
         crystal_filter_enable <= 1'b0;
         watchdog_osc_enable   <= ctl_reg[`OCCS_BIT_WDOSC_EN];
         sysclk_source_select  <= sel_reg;
      end
   end

endmodule
`default_nettype wire

// >>> dv/occs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module occs_checker
(
   input wire logic        ref_clk,               // System clock
   input wire logic        sys_rst,               // Async reset, high
   input wire logic        avs_read,              // Read request
   input wire logic        avs_write,             // Write request
   input wire logic        avs_waitrequest,       // Stall
   input wire logic [31:0] avs_readdata,          // Read data
   input wire logic        wd_osc_clk,            // Watchdog oscillator
   input wire logic        primary_osc_fail,      // Primary failure level
   input wire logic        precision_rc_fast,     // Fast mode
   input wire logic        crystal_filter_enable, // Crystal filter
   input wire logic        watchdog_osc_enable,   // Watchdog oscillator on
   input wire logic [2:0]  sysclk_source_select,  // Effective select
   input wire logic        primary_fail_event,    // Primary failure pulse
   input wire logic        wdosc_fail_event       // Watchdog failure pulse
);
   int quiet;

   // Cycles since the watchdog input last moved; sync delay makes it an upper bound
   always @(posedge ref_clk or posedge sys_rst)
      if (sys_rst)
         quiet <= 0;
      else if (wd_osc_clk != $past(wd_osc_clk))
         quiet <= 0;
      else
         quiet <= quiet + 1;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   ack_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   read_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   filter_off_a: assert property (crystal_filter_enable == 1'b0)
      else $error("crystal filter enabled");
   select_legal_a: assert property (sysclk_source_select <= 3'h4)
      else $error("reserved clock select reached the mux");
   slow_mode_a: assert property (sysclk_source_select == 3'h1 && $stable(sysclk_source_select) |-> !precision_rc_fast)
      else $error("slow select left oscillator fast");
   pfail_cause_a: assert property (primary_fail_event |-> $past(primary_osc_fail, 2) && watchdog_osc_enable)
      else $error("primary failure event without cause");
   pfail_switch_a: assert property (primary_fail_event |-> ##[0:3] sysclk_source_select == 3'h3)
      else $error("no switch to watchdog oscillator");
   wdfail_quiet_a: assert property (wdosc_fail_event |-> quiet >= 8000 && watchdog_osc_enable)
      else $error("watchdog failure declared too early");
   event_pulse_a: assert property (primary_fail_event || wdosc_fail_event |=> !primary_fail_event && !wdosc_fail_event)
      else $error("failure event longer than one cycle");

   cover property (primary_fail_event);
   cover property (wdosc_fail_event);
   cover property (avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

// >>> dv/occs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "occs_map.vh"
module occs_tb_top;
   localparam logic [11:0] c_ctl = `OCCS_CTL_IDX;
   localparam logic [11:0] c_st  = `OCCS_STAT_IDX;
   localparam logic [11:0] c_trm = `OCCS_TRIM_IDX;
   // Crystal settle wait: 5000 cycles of the 20 MHz precision oscillator, in system clocks
   localparam int          c_xtal_wait = (5000 * 50000) / `OCCS_REF_PERIOD_PS;
   logic        ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, xdis, wd_run;
   logic        wd_osc_clk = 1'b0;   // Driven only by the stand-in below
   logic        primary_osc_fail, precision_rc_enable, precision_rc_fast;
   logic        crystal_enable, crystal_pin_override, crystal_filter_enable, watchdog_osc_enable;
   logic        primary_fail_event, wdosc_fail_event;
   logic [13:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic [1:0]  crystal_mode_option, crystal_mode;
   logic [7:0]  trim_option, precision_rc_trim;
   logic [2:0]  sysclk_source_select;
   logic [39:0] rows [10];
   int          mismatches, samples_checked, n;

   occs_top #(.PREC_START_CYC(20)) uut
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wd_osc_clk(wd_osc_clk),
      .primary_osc_fail(primary_osc_fail), .crystal_reset_disable_option(xdis),
      .crystal_mode_option(crystal_mode_option), .trim_option(trim_option),
      .precision_rc_enable(precision_rc_enable), .precision_rc_fast(precision_rc_fast),
      .precision_rc_trim(precision_rc_trim), .crystal_enable(crystal_enable),
      .crystal_pin_override(crystal_pin_override), .crystal_mode(crystal_mode),
      .crystal_filter_enable(crystal_filter_enable), .watchdog_osc_enable(watchdog_osc_enable),
      .sysclk_source_select(sysclk_source_select), .primary_fail_event(primary_fail_event),
      .wdosc_fail_event(wdosc_fail_event)
   );

   // 200 MHz system clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Slow watchdog oscillator stand-in, stoppable to provoke a failure
   always
   begin
      repeat (37) @(posedge ref_clk);
      if (wd_run)
         wd_osc_clk <= ~wd_osc_clk;
   end

   task complete_run;
   begin
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
   begin
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   end
   endtask

   // A spent wait bound is a failure in itself
   task limit(input int cnt, input int lim);
   begin
      if (cnt >= lim)
      begin
         mismatches++;
         complete_run;
      end
   end
   endtask

   // One bus access; request held until waitrequest is sampled low
   task xfer(input logic w, input logic [11:0] idx, input logic [7:0] d);
      int k;
   begin
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      limit(k, 50);
   end
   endtask

   task wr(input logic [11:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask

   task rd_chk(input logic [11:0] idx, input logic [7:0] e, input string nm);
   begin
      xfer(1'b0, idx, 8'h00);
      chk(nm, {24'h0, e}, rd);
   end
   endtask

   task unlock_wr(input logic [7:0] d);
   begin
      wr(c_ctl, `OCCS_KEY_FIRST);
      wr(c_ctl, `OCCS_KEY_SECOND);
      wr(c_ctl, d);
   end
   endtask

   // Two-cycle reset, then the power-up state
   task rst_check;
   begin
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("xtal_boot", !xdis, crystal_enable);
      chk("trim", trim_option, precision_rc_trim);
      chk("xtal_mode", crystal_mode_option, crystal_mode);
      chk("sel", 0, sysclk_source_select);
      rd_chk(c_ctl, `OCCS_CTL_RESET, "ctl_reset");
   end
   endtask

   initial
   begin
      // Keys, data, expected control value, expected select
      rows = '{40'hE7_18_A1_A1_01, 40'h18_E7_55_A1_01, 40'hE7_00_55_A1_01, 40'hE7_18_E0_E0_00,
               40'hE7_18_E2_E2_02, 40'hE7_18_A4_A4_04, 40'hE7_18_A3_A3_03, 40'hE7_18_A5_A5_03,
               40'hE7_18_22_22_03, 40'hE7_18_A0_A0_00};
      {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 48'h0};
      {avs_byteenable, wd_run, primary_osc_fail, xdis} = 7'h7C;
      crystal_mode_option = 2'h2;
      trim_option = 8'h3C;
      mismatches = 0;
      samples_checked = 0;
      rst_check;
      for (int i = 0; i < 10; i++)
      begin
         // Let the crystal settle before a row selects it; only row 4 follows a row that enabled it
         if (rows[i][18:16] == 3'h2)
            repeat (c_xtal_wait) @(posedge ref_clk);
         wr(c_ctl, rows[i][39:32]);
         wr(c_ctl, rows[i][31:24]);
         wr(c_ctl, rows[i][23:16]);
         repeat (30) @(posedge ref_clk);
         rd_chk(c_ctl, rows[i][15:8], "ctl");
         chk("sel", rows[i][7:0], sysclk_source_select);
         chk("fast", rows[i][2:0] != 3'h1, precision_rc_fast);
         chk("prec_en", rows[i][15], precision_rc_enable);
         chk("xtal_pins", rows[i][14], crystal_pin_override);
         chk("wdosc_en", rows[i][13], watchdog_osc_enable);
      end
      // Keys split by other registers, then relock and an unmapped place
      wr(c_ctl, `OCCS_KEY_FIRST);
      wr(c_trm, 8'h5A);
      rd_chk(c_st, 8'h04, "stat_first_key");
      wr(c_ctl, `OCCS_KEY_SECOND);
      wr(c_ctl, 8'hB0);
      rd_chk(c_ctl, 8'hB0, "ctl_split");
      chk("trim_sw", 8'h5A, precision_rc_trim);
      wr(c_ctl, 8'h00);
      rd_chk(c_ctl, 8'hB0, "ctl_relock");
      wr(12'h100, 8'hFF);
      rd_chk(12'h100, 8'h00, "unmapped");
      // Primary failure forces the watchdog oscillator until cleared
      primary_osc_fail <= 1'b1;
      for (n = 0; primary_fail_event !== 1'b1 && n < 20; n++)
         @(posedge ref_clk);
      limit(n, 20);
      repeat (5) @(posedge ref_clk);
      chk("sel_pf", 3, sysclk_source_select);
      xfer(1'b0, c_st, 8'h00);
      chk("pf_flag", 1, rd[0]);
      primary_osc_fail <= 1'b0;
      wr(c_st, 8'h01);
      repeat (5) @(posedge ref_clk);
      chk("sel_back", 0, sysclk_source_select);
      // Watchdog oscillator stops with its detection on
      unlock_wr(8'hA8);
      repeat (200) @(posedge ref_clk);
      wd_run <= 1'b0;
      for (n = 0; wdosc_fail_event !== 1'b1 && n < 9000; n++)
         @(posedge ref_clk);
      limit(n, 9000);
      chk("wd_time", 1, n >= 7960 && n <= 8012);
      xdis <= 1'b1;
      rst_check;
      complete_run;
   end
endmodule

bind occs_top occs_checker chk_i
(
   .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .wd_osc_clk(wd_osc_clk),
   .primary_osc_fail(primary_osc_fail), .precision_rc_fast(precision_rc_fast),
   .crystal_filter_enable(crystal_filter_enable), .watchdog_osc_enable(watchdog_osc_enable),
   .sysclk_source_select(sysclk_source_select), .primary_fail_event(primary_fail_event),
   .wdosc_fail_event(wdosc_fail_event)
);
`default_nettype wire
